// ---- dv/cpurf_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level timing checks
module cpurf_chk
   import cpurf_pkg::*;
(
   input wire logic                ref_clk_in,
   input wire logic                rst_n_in,
   input wire logic [RADDR_W-1:0]  reg_addr_in,
   input wire logic                reg_wr_in,
   input wire logic                reg_rd_in,
   input wire logic [LONG_W-1:0]   reg_rdata_out,
   input wire logic                alu_update_in,
   input wire logic                alu_byte_in,
   input wire logic [WORD_W-1:0]   alu_result_in,
   input wire logic                alu_carry_in,
   input wire logic                alu_overflow_in,
   input wire logic                irq_req_in,
   input wire logic                irq_maskable_in,
   input wire logic [LEVEL_W-1:0]  irq_level_in,
   input wire logic                hw_accept_in,
   input wire logic                sw_int_in,
   input wire logic [SWNUM_W-1:0]  sw_num_in,
   input wire logic                ipl_load_in,
   input wire logic [LEVEL_W-1:0]  ipl_value_in,
   input wire logic                pc_load_in,
   input wire logic [ADDR20_W-1:0] pc_value_in,
   input wire logic                irq_take_out,
   input wire logic [FLAG_W-1:0]   flags_out,
   input wire logic [ADDR20_W-1:0] pc_out
);
   logic              flg_wr;   // Software write to the flag register
   logic [WORD_W-1:0] z_res;    // Result part that the zero flag judges
   logic              sgn;      // Sign bit of the sized result
   assign flg_wr = reg_wr_in && (reg_addr_in == ADR_FLAGS);
   assign z_res  = alu_byte_in ? {8'h00, alu_result_in[7:0]} : alu_result_in;
   assign sgn    = alu_byte_in ? alu_result_in[7] : alu_result_in[15];
   // Single domain; reset silences every check
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_rdata_idle: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == RD_ZERO)
      else $error("read data not idle");
   a_irq_level: assert property (
      irq_take_out == ($past(irq_req_in) && $past(irq_level_in) >
      flags_out[10:8] && (!$past(irq_maskable_in) || flags_out[FLG_I])))
      else $error("interrupt take decision wrong");
   a_hw_clear: assert property (
      hw_accept_in |-> ##2 !flags_out[FLG_I] && !flags_out[FLG_U])
      else $error("hardware accept wrong");
   a_sw_low: assert property (
      sw_int_in && sw_num_in <= SWINT_STACK_MAX |-> ##2
      !flags_out[FLG_I] && !flags_out[FLG_U])
      else $error("low software interrupt wrong");
   a_sw_high: assert property (
      sw_int_in && sw_num_in > SWINT_STACK_MAX && !hw_accept_in && !flg_wr
      |-> ##2 flags_out[FLG_U] == $past(flags_out[FLG_U]) && !flags_out[FLG_I])
      else $error("high software interrupt wrong");
   a_alu_co: assert property (
      alu_update_in |-> ##2 flags_out[FLG_C] == $past(alu_carry_in, 2) &&
      flags_out[FLG_O] == $past(alu_overflow_in, 2))
      else $error("carry or overflow flag wrong");
   a_alu_zero: assert property (
      alu_update_in |-> ##2 flags_out[FLG_Z] == ($past(z_res, 2) == 16'h0000))
      else $error("zero flag wrong");
   a_alu_sign: assert property (
      alu_update_in |-> ##2 flags_out[FLG_S] == $past(sgn, 2))
      else $error("sign flag wrong");
   a_pc_load: assert property (
      pc_load_in |-> ##2 pc_out == $past(pc_value_in, 2))
      else $error("program counter load lost");
   a_ipl_load: assert property (
      ipl_load_in |-> ##2 flags_out[10:8] == $past(ipl_value_in, 2))
      else $error("priority level load lost");
endmodule : cpurf_chk

bind cpurf_top cpurf_chk i_cpurf_chk (.*);
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpurf_pkg::*;
   logic                ref_clk_in = 1'b0;
   logic                rst_n_in = 1'b0;
   logic [RADDR_W-1:0]  reg_addr_in = '0;
   logic [LONG_W-1:0]   reg_wdata_in = '0;
   logic [LONG_W-1:0]   reg_rdata_out, data_pair_low_32_out;
   logic [LONG_W-1:0]   data_pair_high_32_out, address_pair_32_out;
   logic                reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_take_out;
   logic                alu_update_in = 1'b0, alu_byte_in = 1'b0;
   logic [WORD_W-1:0]   alu_result_in = '0, active_sp_out;
   logic                alu_carry_in = 1'b0, alu_overflow_in = 1'b0;
   logic                irq_req_in = 1'b0, irq_maskable_in = 1'b0;
   logic [LEVEL_W-1:0]  irq_level_in = '0, ipl_value_in = '0;
   logic                hw_accept_in = 1'b0, sw_int_in = 1'b0;
   logic [SWNUM_W-1:0]  sw_num_in = '0;
   logic                ipl_load_in = 1'b0, pc_load_in = 1'b0;
   logic [ADDR20_W-1:0] pc_value_in = '0, pc_out, vtb_out;
   logic [FLAG_W-1:0]   flags_out;
   int                  mismatches = 0, checked = 0, cyc = 0;

   cpurf_top i_cpurf_top (.*);

   // 25 MHz clock
   always #20 ref_clk_in = ~ref_clk_in;

   task automatic step;
      @(posedge ref_clk_in);
   endtask : step

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      step;
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      step;
      reg_wr_in <= 1'b0;
   endtask : wr

   // Read, data checked next cycle
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      step;
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      step;
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask : rdc

   task automatic irq(input logic [2:0] l, input logic m, input logic e);
      step;
      irq_req_in      <= 1'b1;
      irq_level_in    <= l;
      irq_maskable_in <= m;
      step;
      irq_req_in <= 1'b0;
      #1 chk({31'h0, irq_take_out}, {31'h0, e});
   endtask : irq

   task automatic sw(input logic [5:0] n);
      step;
      sw_int_in <= 1'b1;
      sw_num_in <= n;
      step;
      sw_int_in <= 1'b0;
   endtask : sw

   // Reset values, map, pairs, hole
   task automatic t_map;
      logic [31:0] d;
      for (int a = 0; a < 21; a++)
         rdc(5'(a), 32'h0);
      for (int a = 0; a < 12; a++)
         wr(5'(a), 32'hfffb_0101 + a * 32'h1111);
      for (int a = 0; a < 12; a++)
      begin
         d = 32'hfffb_0101 + a * 32'h1111;
         rdc(5'(a), d & ((a == 7 || a == 8) ? 32'hf_ffff : 32'hffff));
      end
      rdc(ADR_PAIR_LO, 32'h2323_0101);
      rdc(ADR_PAIR_HI, 32'h3434_1212);
      rdc(ADR_APAIR, 32'h5656_4545);
      rdc(ADR_D0_UP, 32'h01);
      rdc(ADR_D1_LO, 32'h12);
      chk(data_pair_low_32_out, 32'h2323_0101);
      chk(data_pair_high_32_out, 32'h3434_1212);
      chk(address_pair_32_out, 32'h5656_4545);
      chk(32'(pc_out), 32'hb_8989);
      chk(32'(vtb_out), 32'hb_7878);
      wr(5'h1f, 32'hffff_ffff);
      rdc(5'h1f, 32'h0);
      $display("t_map done");
   endtask : t_map

   // Wide and narrow writes only touch their own part
   task automatic t_pairs;
      wr(ADR_PAIR_LO, 32'h1234_5678);
      rdc(ADR_DATA2, 32'h1234);
      wr(ADR_D0_UP, 32'hab);
      rdc(ADR_DATA0, 32'hab78);
      wr(ADR_D1_LO, 32'hcd);
      rdc(ADR_DATA1, 32'h12cd);
      wr(ADR_APAIR, 32'h9abc_def0);
      rdc(ADR_ADDR1, 32'h9abc);
      $display("t_pairs done");
   endtask : t_pairs

   // Bank 1 is separate; shared registers do not move
   task automatic t_bank;
      wr(ADR_FLAGS, 32'h010);
      rdc(ADR_DATA0, 32'h0);
      wr(ADR_DATA0, 32'hbeef);
      rdc(ADR_PC, 32'hb_8989);
      rdc(ADR_FLAGS, 32'h010);
      wr(ADR_FLAGS, 32'h000);
      rdc(ADR_DATA0, 32'hab78);
      $display("t_bank done");
   endtask : t_bank

   // Word then byte ALU update
   task automatic t_alu;
      step;
      alu_update_in   <= 1'b1;
      alu_result_in   <= 16'h8000;
      alu_carry_in    <= 1'b1;
      step;
      alu_byte_in     <= 1'b1;
      alu_result_in   <= 16'h0100;
      alu_carry_in    <= 1'b0;
      alu_overflow_in <= 1'b1;
      step;
      alu_update_in <= 1'b0;
      rdc(ADR_FLAGS, 32'h024);
      $display("t_alu done");
   endtask : t_alu

   task automatic t_irq;
      wr(ADR_FLAGS, 32'h340);
      irq(3'h3, 1'b1, 1'b0);
      irq(3'h4, 1'b1, 1'b1);
      wr(ADR_FLAGS, 32'h300);
      irq(3'h7, 1'b1, 1'b0);
      irq(3'h4, 1'b0, 1'b1);
      step;
      ipl_load_in  <= 1'b1;
      ipl_value_in <= 3'h7;
      pc_load_in   <= 1'b1;
      pc_value_in  <= 20'h5_a5a5;
      step;
      ipl_load_in <= 1'b0;
      pc_load_in  <= 1'b0;
      irq(3'h7, 1'b0, 1'b0);
      rdc(ADR_FLAGS, 32'h700);
      rdc(ADR_PC, 32'h5_a5a5);
      $display("t_irq done");
   endtask : t_irq

   // Stack choice and clearing by accepted interrupts
   task automatic t_stack;
      wr(ADR_USP, 32'h1111);
      wr(ADR_ISP, 32'h2222);
      wr(ADR_FLAGS, 32'h0c0);
      rdc(ADR_SP, 32'h1111);
      chk(32'(active_sp_out), 32'h1111);
      sw(6'h20);
      rdc(ADR_FLAGS, 32'h080);
      sw(6'h1f);
      rdc(ADR_FLAGS, 32'h000);
      rdc(ADR_SP, 32'h2222);
      wr(ADR_FLAGS, 32'h0c0);
      step;
      hw_accept_in <= 1'b1;
      step;
      hw_accept_in <= 1'b0;
      rdc(ADR_FLAGS, 32'h000);
      $display("t_stack done");
   endtask : t_stack

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // Hang guard
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         $display("ERROR at %0t ns: timeout", $time);
         wrap_up;
      end
   end

   initial
   begin
      repeat (20) step;
      rst_n_in <= 1'b1;
      t_map;
      t_pairs;
      t_bank;
      t_alu;
      t_irq;
      t_stack;
      wrap_up;
   end
endmodule : tb
`default_nettype wire

// ---- rtl/cpurf_pkg.sv ----
// Summary of operation
// RULE1: Thirteen registers; seven of them duplicated per bank
// RULE2: Sixteen-bit data registers; first two byte-addressable
// RULE3: Data pairs form two 32-bit registers
// RULE4: Sixteen-bit address registers, general operands too
// RULE5: Address register 1:0 form one 32-bit register
// RULE6: Sixteen-bit frame base for relative addressing
// RULE7: Twenty-bit vector table base register
// RULE8: Twenty-bit program counter, next instruction address
// RULE9: Stack select flag picks interrupt or user pointer
// RULE10: Interrupt acceptance or low software interrupt clears stack select
// RULE11: Sixteen-bit static base for relative addressing
// RULE12: Eleven-bit flag register with priority level field
// RULE13: Carry flag captures ALU carry or shift-out
// RULE14: Zero flag set when result is zero
// RULE15: Sign flag set when result is negative
// RULE16: Bank select flag chooses register bank
// RULE17: Overflow flag set when operation overflows
// RULE18: Interrupt enable flag gates maskable interrupts
// RULE19: Accepting an interrupt clears interrupt enable
// RULE20: Priority level field is three bits, 0-7
// RULE21: Interrupt taken only above current priority level
// RULE22: Reserved flag bit written zero, reads undefined
// RULE23: Bank switch affects only the seven banked registers
// RULE24: Debug flag stored plainly, no debug behaviour
package cpurf_pkg;

   // Widths
   localparam int WORD_W    = 16;           // Data, address, pointer width
   localparam int BYTE_W    = 8;            // Half of a data register
   localparam int LONG_W    = 32;           // Paired register width
   localparam int ADDR20_W  = 20;           // Program counter and table base
   localparam int FLAG_W    = 11;           // Flag register width
   localparam int LEVEL_W   = 3;            // Priority level width
   localparam int RADDR_W   = 5;            // Software port address width
   localparam int SWNUM_W   = 6;            // Software interrupt number width

   // Software port register addresses
   localparam logic [4:0] ADR_DATA0    = 5'h00; // data_register_0
   localparam logic [4:0] ADR_DATA1    = 5'h01; // data_register_1
   localparam logic [4:0] ADR_DATA2    = 5'h02; // data_register_2
   localparam logic [4:0] ADR_DATA3    = 5'h03; // data_register_3
   localparam logic [4:0] ADR_ADDR0    = 5'h04; // address_register_0
   localparam logic [4:0] ADR_ADDR1    = 5'h05; // address_register_1
   localparam logic [4:0] ADR_FB       = 5'h06; // frame_base
   localparam logic [4:0] ADR_VTB      = 5'h07; // vector_table_base
   localparam logic [4:0] ADR_PC       = 5'h08; // program_counter
   localparam logic [4:0] ADR_USP      = 5'h09; // user_stack_pointer
   localparam logic [4:0] ADR_ISP      = 5'h0a; // interrupt_stack_pointer
   localparam logic [4:0] ADR_SB       = 5'h0b; // static_base
   localparam logic [4:0] ADR_FLAGS    = 5'h0c; // cpu_flags
   localparam logic [4:0] ADR_D0_UP    = 5'h0d; // data_register_0_upper
   localparam logic [4:0] ADR_D0_LO    = 5'h0e; // data_register_0_lower
   localparam logic [4:0] ADR_D1_UP    = 5'h0f; // data_register_1_upper
   localparam logic [4:0] ADR_D1_LO    = 5'h10; // data_register_1_lower
   localparam logic [4:0] ADR_PAIR_LO  = 5'h11; // data_pair_low_32
   localparam logic [4:0] ADR_PAIR_HI  = 5'h12; // data_pair_high_32
   localparam logic [4:0] ADR_APAIR    = 5'h13; // address_pair_32
   localparam logic [4:0] ADR_SP       = 5'h14; // Active stack pointer

   // Flag register bit positions
   localparam int FLG_C    = 0;             // Carry
   localparam int FLG_D    = 1;             // Debug
   localparam int FLG_Z    = 2;             // Zero
   localparam int FLG_S    = 3;             // Sign
   localparam int FLG_B    = 4;             // Bank select
   localparam int FLG_O    = 5;             // Overflow
   localparam int FLG_I    = 6;             // Interrupt enable
   localparam int FLG_U    = 7;             // Stack select
   localparam int FLG_IPL  = 8;             // Priority level, low bit
   localparam int FLG_RSV  = 11;            // Reserved, not stored

   // Reset values
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [19:0] RST_A20   = 20'h00000;
   localparam logic [10:0] RST_FLAGS = 11'h000;
   localparam logic [31:0] RD_ZERO   = 32'h00000000;

   // Highest software interrupt number that switches stacks
   localparam logic [5:0] SWINT_STACK_MAX = 6'h1f;

endpackage : cpurf_pkg

// ---- rtl/cpurf_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpurf_top
   import cpurf_pkg::*;
(
   input  wire logic                 ref_clk_in,      // 25 MHz CPU clock
   input  wire logic                 rst_n_in,        // Sync reset, low
   // Software register port
   input  wire logic [RADDR_W-1:0]   reg_addr_in,     // Register address
   input  wire logic [LONG_W-1:0]    reg_wdata_in,    // Write data
   input  wire logic                 reg_wr_in,       // Write strobe
   input  wire logic                 reg_rd_in,       // Read strobe
   output logic [LONG_W-1:0]         reg_rdata_out,   // Read data, next cycle
   // ALU flag update
   input  wire logic                 alu_update_in,   // Update C,Z,S,O
   input  wire logic                 alu_byte_in,     // Byte-sized result
   input  wire logic [WORD_W-1:0]    alu_result_in,   // ALU result
   input  wire logic                 alu_carry_in,    // Carry/borrow/shift-out
   input  wire logic                 alu_overflow_in, // Overflow
   // Interrupt arbitration and acceptance
   input  wire logic                 irq_req_in,      // Interrupt requested
   input  wire logic                 irq_maskable_in, // Request is maskable
   input  wire logic [LEVEL_W-1:0]   irq_level_in,    // Request priority
   input  wire logic                 hw_accept_in,    // Hardware irq accepted
   input  wire logic                 sw_int_in,       // Software irq executed
   input  wire logic [SWNUM_W-1:0]   sw_num_in,       // Software irq number
   input  wire logic                 ipl_load_in,     // Load new priority
   input  wire logic [LEVEL_W-1:0]   ipl_value_in,    // New priority level
   input  wire logic                 pc_load_in,      // Load program counter
   input  wire logic [ADDR20_W-1:0]  pc_value_in,     // New PC value
   output logic                      irq_take_out,    // Request may be taken
   output logic [FLAG_W-1:0]         flags_out,       // Current flags
   output logic [WORD_W-1:0]         active_sp_out,   // Selected stack ptr
   output logic [ADDR20_W-1:0]       pc_out,          // Program counter
   output logic [ADDR20_W-1:0]       vtb_out,         // Vector table base
   output logic [LONG_W-1:0]         data_pair_low_32_out,  // Pair 2:0
   output logic [LONG_W-1:0]         data_pair_high_32_out, // Pair 3:1
   output logic [LONG_W-1:0]         address_pair_32_out    // Pair a1:a0
);

   // Replace one byte of a word, upper or lower half
   function automatic logic [WORD_W-1:0] merge_byte
   (
      input logic [WORD_W-1:0] old_word,
      input logic [BYTE_W-1:0] new_byte,
      input logic              upper
   );
      logic [WORD_W-1:0] res;
      res = old_word;
      if (upper)
      begin
         res[WORD_W-1:BYTE_W] = new_byte;
      end
      else
      begin
         res[BYTE_W-1:0] = new_byte;
      end
      return res;
   endfunction : merge_byte

   // Sign bit of a byte or word result
   function automatic logic result_neg
   (
      input logic [WORD_W-1:0] res,
      input logic              is_byte
   );
      return is_byte ? res[BYTE_W-1] : res[WORD_W-1];
   endfunction : result_neg

   // Banked storage, indexed by the bank select flag
   logic [WORD_W-1:0]   data_ff [2][4];   // Four data registers per bank
   logic [WORD_W-1:0]   addr_ff [2][2];   // Two address registers per bank
   logic [WORD_W-1:0]   fb_ff   [2];      // Frame base per bank
   // Shared storage
   logic [ADDR20_W-1:0] vtb_ff;           // Vector table base
   logic [ADDR20_W-1:0] pc_ff;            // Program counter
   logic [WORD_W-1:0]   usp_ff;           // User stack pointer
   logic [WORD_W-1:0]   isp_ff;           // Interrupt stack pointer
   logic [WORD_W-1:0]   sb_ff;            // Static base
   logic [FLAG_W-1:0]   flags_ff;         // Flag register
   logic [FLAG_W-1:0]   nxt_flags;        // Flags after this cycle

   logic                bank;             // Active bank
   logic                wr_hit;           // Qualified write
   logic [WORD_W-1:0]   wd16;             // Low half of write data
   logic [WORD_W-1:0]   wd_hi;            // High half of write data
   logic [WORD_W-1:0]   cur_sp;           // Selected stack pointer
   logic [LONG_W-1:0]   rd_mux;           // Read selection

   // Bank and stack selection follow the stored flags
   assign bank   = flags_ff[FLG_B];                               // RULE16
   assign cur_sp = flags_ff[FLG_U] ? usp_ff : isp_ff;             // RULE9
   assign wr_hit = reg_wr_in;
   assign wd16   = reg_wdata_in[WORD_W-1:0];
   assign wd_hi  = reg_wdata_in[LONG_W-1:WORD_W];

   // Data registers of the active bank only; the other bank is kept
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int b = 0; b < 2; b++)
         begin
            for (int r = 0; r < 4; r++)
            begin
               data_ff[b][r] <= RST_WORD;                         // RULE1
            end
         end
      end
      else if (wr_hit)
      begin
         unique case (reg_addr_in)
            ADR_DATA0: data_ff[bank][0] <= wd16;                  // RULE2
            ADR_DATA1: data_ff[bank][1] <= wd16;                  // RULE2
            ADR_DATA2: data_ff[bank][2] <= wd16;                  // RULE2
            ADR_DATA3: data_ff[bank][3] <= wd16;                  // RULE2
            ADR_D0_UP: data_ff[bank][0] <=
               merge_byte(data_ff[bank][0], wd16[BYTE_W-1:0], 1'b1); // RULE2
            ADR_D0_LO: data_ff[bank][0] <=
               merge_byte(data_ff[bank][0], wd16[BYTE_W-1:0], 1'b0); // RULE2
            ADR_D1_UP: data_ff[bank][1] <=
               merge_byte(data_ff[bank][1], wd16[BYTE_W-1:0], 1'b1); // RULE2
            ADR_D1_LO: data_ff[bank][1] <=
               merge_byte(data_ff[bank][1], wd16[BYTE_W-1:0], 1'b0); // RULE2
            ADR_PAIR_LO:
            begin
               // Register 2 is the upper half of this pair
               data_ff[bank][2] <= wd_hi;                         // RULE3
               data_ff[bank][0] <= wd16;                          // RULE3
            end
            ADR_PAIR_HI:
            begin
               data_ff[bank][3] <= wd_hi;                         // RULE3
               data_ff[bank][1] <= wd16;                          // RULE3
            end
            default: ;                                            // Others
         endcase
      end
   end

   // Address registers and frame base of the active bank
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int b = 0; b < 2; b++)
         begin
            addr_ff[b][0] <= RST_WORD;
            addr_ff[b][1] <= RST_WORD;
            fb_ff[b]      <= RST_WORD;
         end
      end
      else if (wr_hit)
      begin
         unique case (reg_addr_in)
            ADR_ADDR0: addr_ff[bank][0] <= wd16;                  // RULE4
            ADR_ADDR1: addr_ff[bank][1] <= wd16;                  // RULE4
            ADR_APAIR:
            begin
               // Register 1 forms the upper half
               addr_ff[bank][1] <= wd_hi;                         // RULE5
               addr_ff[bank][0] <= wd16;                          // RULE5
            end
            ADR_FB:    fb_ff[bank] <= wd16;                       // RULE6
            default: ;                                            // Others
         endcase
      end
   end

   // Shared registers, untouched by the bank flag
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         vtb_ff <= RST_A20;
         usp_ff <= RST_WORD;
         isp_ff <= RST_WORD;
         sb_ff  <= RST_WORD;
      end
      else if (wr_hit)
      begin
         unique case (reg_addr_in)
            ADR_VTB: vtb_ff <= reg_wdata_in[ADDR20_W-1:0];        // RULE7
            ADR_USP: usp_ff <= wd16;                              // RULE23
            ADR_ISP: isp_ff <= wd16;                              // RULE23
            ADR_SB:  sb_ff  <= wd16;                              // RULE11
            ADR_SP:
            begin
               // Writes go to whichever pointer is active now
               if (flags_ff[FLG_U])                               // RULE9
               begin
                  usp_ff <= wd16;
               end
               else
               begin
                  isp_ff <= wd16;
               end
            end
            default: ;                                            // Others
         endcase
      end
   end

   // Program counter; a CPU load wins over a software write
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         pc_ff <= RST_A20;
      end
      else if (pc_load_in)
      begin
         pc_ff <= pc_value_in;                                    // RULE8
      end
      else if (wr_hit && reg_addr_in == ADR_PC)
      begin
         pc_ff <= reg_wdata_in[ADDR20_W-1:0];                     // RULE8
      end
   end

   // Next flags: software write first, then hardware events on top,
   // so an event in the same cycle as a write is never lost
   always_comb
   begin
      nxt_flags = flags_ff;
      if (wr_hit && reg_addr_in == ADR_FLAGS)
      begin
         // Debug bit is stored as written and does nothing else
         nxt_flags = reg_wdata_in[FLAG_W-1:0];                    // RULE24
      end
      if (alu_update_in)
      begin
         nxt_flags[FLG_C] = alu_carry_in;                         // RULE13
         nxt_flags[FLG_Z] = alu_byte_in ?                         // RULE14
            (alu_result_in[BYTE_W-1:0] == '0) :
            (alu_result_in == '0);
         nxt_flags[FLG_S] = result_neg(alu_result_in, alu_byte_in); // RULE15
         nxt_flags[FLG_O] = alu_overflow_in;                      // RULE17
      end
      if (hw_accept_in || sw_int_in)
      begin
         nxt_flags[FLG_I] = 1'b0;                                 // RULE19
      end
      if (hw_accept_in || (sw_int_in && sw_num_in <= SWINT_STACK_MAX))
      begin
         nxt_flags[FLG_U] = 1'b0;                                 // RULE10
      end
      if (ipl_load_in)
      begin
         nxt_flags[FLG_IPL +: LEVEL_W] = ipl_value_in;            // RULE20
      end
   end

   // Flag register; reserved position is never stored
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         flags_ff <= RST_FLAGS;                                   // RULE12
      end
      else
      begin
         flags_ff <= nxt_flags;                                   // RULE22
      end
   end

   // Read selection from the active bank and shared registers
   always_comb
   begin
      rd_mux = RD_ZERO;
      unique case (reg_addr_in)
         ADR_DATA0:   rd_mux[WORD_W-1:0] = data_ff[bank][0];
         ADR_DATA1:   rd_mux[WORD_W-1:0] = data_ff[bank][1];
         ADR_DATA2:   rd_mux[WORD_W-1:0] = data_ff[bank][2];
         ADR_DATA3:   rd_mux[WORD_W-1:0] = data_ff[bank][3];
         ADR_ADDR0:   rd_mux[WORD_W-1:0] = addr_ff[bank][0];
         ADR_ADDR1:   rd_mux[WORD_W-1:0] = addr_ff[bank][1];
         ADR_FB:      rd_mux[WORD_W-1:0] = fb_ff[bank];
         ADR_VTB:     rd_mux[ADDR20_W-1:0] = vtb_ff;
         ADR_PC:      rd_mux[ADDR20_W-1:0] = pc_ff;
         ADR_USP:     rd_mux[WORD_W-1:0] = usp_ff;
         ADR_ISP:     rd_mux[WORD_W-1:0] = isp_ff;
         ADR_SB:      rd_mux[WORD_W-1:0] = sb_ff;
         // Reserved position reads as zero here
         ADR_FLAGS:   rd_mux[FLAG_W-1:0] = flags_ff;              // RULE22
         ADR_D0_UP:   rd_mux[BYTE_W-1:0] = data_ff[bank][0][WORD_W-1:BYTE_W];
         ADR_D0_LO:   rd_mux[BYTE_W-1:0] = data_ff[bank][0][BYTE_W-1:0];
         ADR_D1_UP:   rd_mux[BYTE_W-1:0] = data_ff[bank][1][WORD_W-1:BYTE_W];
         ADR_D1_LO:   rd_mux[BYTE_W-1:0] = data_ff[bank][1][BYTE_W-1:0];
         ADR_PAIR_LO: rd_mux = {data_ff[bank][2], data_ff[bank][0]}; // RULE3
         ADR_PAIR_HI: rd_mux = {data_ff[bank][3], data_ff[bank][1]}; // RULE3
         ADR_APAIR:   rd_mux = {addr_ff[bank][1], addr_ff[bank][0]}; // RULE5
         ADR_SP:      rd_mux[WORD_W-1:0] = cur_sp;                // RULE9
         default:     rd_mux = RD_ZERO;                           // Unmapped
      endcase
   end

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         reg_rdata_out <= RD_ZERO;
      end
      else if (reg_rd_in)
      begin
         reg_rdata_out <= rd_mux;
      end
      else
      begin
         reg_rdata_out <= RD_ZERO;
      end
   end

   // Interrupt gate, judged on the stored flags; non-maskable
   // requests still need a level above the current one
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         irq_take_out <= 1'b0;
      end
      else
      begin
         irq_take_out <= irq_req_in
            && (!irq_maskable_in || flags_ff[FLG_I])              // RULE18
            && (irq_level_in > flags_ff[FLG_IPL +: LEVEL_W]);     // RULE21
      end
   end

   // Mirror outputs, updated one edge after the stored state
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         flags_out             <= RST_FLAGS;
         active_sp_out         <= RST_WORD;
         pc_out                <= RST_A20;
         vtb_out               <= RST_A20;
         data_pair_low_32_out  <= RD_ZERO;
         data_pair_high_32_out <= RD_ZERO;
         address_pair_32_out   <= RD_ZERO;
      end
      else
      begin
         flags_out             <= flags_ff;
         active_sp_out         <= cur_sp;                         // RULE9
         pc_out                <= pc_ff;
         vtb_out               <= vtb_ff;
         data_pair_low_32_out  <= {data_ff[bank][2], data_ff[bank][0]};
         data_pair_high_32_out <= {data_ff[bank][3], data_ff[bank][1]};
         address_pair_32_out   <= {addr_ff[bank][1], addr_ff[bank][0]};
      end
   end

endmodule : cpurf_top
`default_nettype wire
